// >>> bench/slp_far_side.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// external pins, uart and lin transceiver seen from the pins
// ****************************************************************
module slp_far_side (
    // pin side of the mux
    input  wire logic [3:0] pinOut,
    input  wire logic [3:0] pinOeN,
    output var  logic [3:0] pinIn,
    // uart and transceiver lines
    output var  logic       uartTx,
    output var  logic       linRxd,
    // random levels from the bench, changed after each edge
    input  wire logic [5:0] noise
);
    // a driven pin reads back its own level; a released one shows whatever
    // the board drives, which is redrawn at random every cycle so stale values are soon caught
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pinIn[i] = pinOeN[i] ? noise[i] : pinOut[i];
        end
        uartTx = noise[4];
        linRxd = noise[5];
    end
endmodule
`default_nettype wire

// >>> bench/test_serial_lin_pin_function_mux.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// pin mux bench: model compared at every edge
// ****************************************************************
module test_serial_lin_pin_function_mux;
    logic        clk, rstn, regWr, regRd, linTxPad, uartTx, uartRx, linRxd;
    logic        linTxd, linSyncRx, linDiagEn, eTx, eRx, eSync, eDiag, expV;
    logic [31:0] regAddr, regWdata, regRdata, m1, m2, eRd, eSt;
    logic [3:0]  gpioOut, gpioOeN, pinIn, pinOut, pinOeN, eOut, eOeN;
    logic [5:0]  noise;
    int          err_total, checks_done, cycN;

    slp_pin_mux uut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .gpioOut(gpioOut),
        .gpioOeN(gpioOeN), .linTxPad(linTxPad), .pinIn(pinIn), .pinOut(pinOut),
        .pinOeN(pinOeN), .uartTx(uartTx), .uartRx(uartRx), .linRxd(linRxd),
        .linTxd(linTxd), .linSyncRx(linSyncRx), .linDiagEn(linDiagEn));
    slp_far_side far (.pinOut(pinOut), .pinOeN(pinOeN), .pinIn(pinIn),
        .uartTx(uartTx), .linRxd(linRxd), .noise(noise));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one bus cycle with fresh random levels on every other input
    task automatic cyc(input logic w, input logic r, input logic [31:0] a,
                       input logic [31:0] d);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWdata <= d;
        gpioOut <= 4'($urandom);
        gpioOeN <= 4'($urandom);
        linTxPad <= 1'($urandom);
        noise <= 6'($urandom);
        @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // the model: outputs seen at this edge must match what was due last edge
    always @(posedge clk) begin
        cycN++;
        if (cycN == 5000) begin
            err_total++;
            test_done();
        end
        if (!rstn) begin
            if (cycN > 2) begin
                chk(regRdata, 32'h0000_0000);
                chk({24'h00_0000, pinOut, pinOeN}, 32'h0000_000f);
                chk({uartRx, linTxd, linSyncRx, linDiagEn}, 4'hf);
            end
            m1 = slp_pkg::P1_SEL_RESET;
            m2 = slp_pkg::P2_SEL_RESET;
            // serial lines come out of reset idle high
            {eTx, eRx} = 2'b11;
            expV = 1'b0;
        end else begin
            if (expV) begin
                chk(pinOeN, eOeN);
                chk(pinOut | eOeN, eOut | eOeN);
                chk(linTxd, eTx);
                chk(uartRx, eRx);
                chk({linSyncRx, linDiagEn}, {eSync, eDiag});
                chk(regRdata, eRd);
            end
            // status shows the lines as they stand now, i.e. last edge's expectations
            eSt = 32'h0000_0000;
            eSt[slp_pkg::ST_LIN_TXD_BIT] = eTx;
            eSt[slp_pkg::ST_LIN_RXD_BIT] = linRxd;
            eSt[slp_pkg::ST_UART_RX_BIT] = eRx;
            eOut = gpioOut;
            eOeN = gpioOeN;
            if (m1[slp_pkg::P1_UART_RX_BIT]) eOeN[slp_pkg::PIN_UART_RX] = 1'b1;
            if (m1[slp_pkg::P1_UART_TX_BIT]) begin
                eOut[slp_pkg::PIN_UART_TX] = uartTx;
                eOeN[slp_pkg::PIN_UART_TX] = 1'b0;
            end
            if (m2[slp_pkg::P2_LIN_TX_IN_BIT]) eOeN[slp_pkg::PIN_LIN_TX_IN] = 1'b1;
            if (m2[slp_pkg::P2_LIN_RX_OUT_BIT]) begin
                eOut[slp_pkg::PIN_LIN_RX_OUT] = linRxd;
                eOeN[slp_pkg::PIN_LIN_RX_OUT] = 1'b0;
            end
            // standalone pin beats the uart route, which beats the pad
            eTx = m2[slp_pkg::P2_LIN_TX_IN_BIT] ? pinIn[slp_pkg::PIN_LIN_TX_IN]
                : (m2[slp_pkg::P2_UART_TX_LIN_BIT] ? uartTx : linTxPad);
            eRx = m2[slp_pkg::P2_LIN_RX_EN_BIT] ? linRxd
                : (m1[slp_pkg::P1_UART_RX_BIT] ? pinIn[slp_pkg::PIN_UART_RX] : 1'b1);
            eSync = m2[slp_pkg::P2_LIN_RX_EN_BIT] ? linRxd : 1'b1;
            eDiag = ~m2[slp_pkg::P2_LIN_RX_EN_BIT];
            eRd = 32'h0000_0000;
            if (regRd && regAddr == slp_pkg::P1_SEL_ADDR) eRd = m1;
            if (regRd && regAddr == slp_pkg::P2_SEL_ADDR) eRd = m2;
            if (regRd && regAddr == slp_pkg::STATUS_ADDR) eRd = eSt;
            if (regWr && regAddr == slp_pkg::P1_SEL_ADDR) m1 = regWdata & slp_pkg::P1_SEL_MASK;
            if (regWr && regAddr == slp_pkg::P2_SEL_ADDR) m2 = regWdata & slp_pkg::P2_SEL_MASK;
            expV = 1'b1;
        end
    end

    initial begin
        logic [31:0] p1, p2;
        {regWr, regRd, linTxPad} = 3'b000;
        {regAddr, regWdata} = 64'h0;
        {gpioOut, gpioOeN, noise} = 14'h0;
        {err_total, checks_done, cycN} = 0;
        rstn = 1'b0;
        void'($urandom(32'h96b9_608d));
        repeat (16) cyc(1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
        rstn <= 1'b1;
        // every selection of both registers; reserved bits written zero
        for (int i = 0; i < 64; i++) begin
            p1 = {27'h0, i[1], 3'h0, i[0]};
            p2 = {11'h0, i[5], 3'h0, i[4], 11'h0, i[3], 3'h0, i[2]};
            cyc(1'b1, 1'b0, slp_pkg::P1_SEL_ADDR, p1);
            cyc(1'b1, 1'b0, slp_pkg::P2_SEL_ADDR, p2);
            cyc(1'b0, 1'b1, slp_pkg::P1_SEL_ADDR, 32'h0000_0000);
            cyc(1'b0, 1'b1, slp_pkg::P2_SEL_ADDR, 32'h0000_0000);
            repeat (8) cyc(1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
            cyc(1'b0, 1'b1, slp_pkg::STATUS_ADDR, 32'h0000_0000);
        end
        $display("test routing done");
        // unmapped place and reserved bits are not stored
        cyc(1'b1, 1'b0, 32'hffff_0d10, 32'hffff_ffff);
        cyc(1'b0, 1'b1, 32'hffff_0d10, 32'h0000_0000);
        cyc(1'b1, 1'b0, slp_pkg::P1_SEL_ADDR, 32'hffff_ffff);
        cyc(1'b1, 1'b0, slp_pkg::P2_SEL_ADDR, 32'hffff_ffff);
        cyc(1'b0, 1'b1, slp_pkg::P1_SEL_ADDR, 32'h0000_0000);
        cyc(1'b0, 1'b1, slp_pkg::P2_SEL_ADDR, 32'h0000_0000);
        repeat (4) cyc(1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
        $display("test unmapped done");
        // reset in mid-run must clear both selects
        rstn <= 1'b0;
        repeat (4) cyc(1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
        rstn <= 1'b1;
        cyc(1'b0, 1'b1, slp_pkg::P1_SEL_ADDR, 32'h0000_0000);
        cyc(1'b0, 1'b1, slp_pkg::P2_SEL_ADDR, 32'h0000_0000);
        repeat (4) cyc(1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
        $display("test reset done");
        test_done();
    end
endmodule
`default_nettype wire

// >>> design/slp_pin_mux.sv
`timescale 1ns/1ns
`default_nettype none
module slp_pin_mux (
    // clock and reset
    input  wire  logic        clk,
    input  wire  logic        rstn,
    // register port
    input  wire  logic [31:0] regAddr,
    input  wire  logic [31:0] regWdata,
    input  wire  logic        regWr,
    input  wire  logic        regRd,
    output var   logic [31:0] regRdata,
    // general-purpose port side, pin order rx, tx, lin-in, lin-out
    input  wire  logic [3:0]  gpioOut,
    input  wire  logic [3:0]  gpioOeN,
    input  wire  logic        linTxPad,
    // pins
    input  wire  logic [3:0]  pinIn,
    output var   logic [3:0]  pinOut,
    output var   logic [3:0]  pinOeN,
    // uart
    input  wire  logic        uartTx,
    output var   logic        uartRx,
    // lin transceiver and sync logic
    input  wire  logic        linRxd,
    output var   logic        linTxd,
    output var   logic        linSyncRx,
    output var   logic        linDiagEn
);
    // ****************************************************************
    // registers
    // ****************************************************************
    logic [31:0] p1Sel_r;
    logic [31:0] p1Sel_nxt;
    logic [31:0] p2Sel_r;
    logic [31:0] p2Sel_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] status;

    // reserved bits are masked off, so a careless write cannot alter routing
    always_comb begin
        p1Sel_nxt = p1Sel_r;
        p2Sel_nxt = p2Sel_r;
        rdata_nxt = 32'h0000_0000;
        if (regWr && regAddr == slp_pkg::P1_SEL_ADDR) begin
            p1Sel_nxt = regWdata & slp_pkg::P1_SEL_MASK;
        end
        if (regWr && regAddr == slp_pkg::P2_SEL_ADDR) begin
            p2Sel_nxt = regWdata & slp_pkg::P2_SEL_MASK;
        end
        if (regRd) begin
            unique case (regAddr)
                slp_pkg::P1_SEL_ADDR: rdata_nxt = p1Sel_r;
                slp_pkg::P2_SEL_ADDR: rdata_nxt = p2Sel_r;
                slp_pkg::STATUS_ADDR: rdata_nxt = status;
                default:              rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // status shows the lines as the block currently drives and sees them
    always_comb begin
        status = 32'h0000_0000;
        status[slp_pkg::ST_LIN_TXD_BIT] = linTxd;
        status[slp_pkg::ST_LIN_RXD_BIT] = linRxd;
        status[slp_pkg::ST_UART_RX_BIT] = uartRx;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p1Sel_r <= slp_pkg::P1_SEL_RESET;
            p2Sel_r <= slp_pkg::P2_SEL_RESET;
            rdata_r <= 32'h0000_0000;
        end else begin
            p1Sel_r <= p1Sel_nxt;
            p2Sel_r <= p2Sel_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign regRdata = rdata_r;

    // ****************************************************************
    // pin routing
    // ****************************************************************
    slp_route_if #(.N(slp_pkg::PIN_COUNT)) rt ();

    logic selUartRx;
    logic selUartTx;
    logic selLinTxIn;
    logic selLinRxOut;
    logic linRxEn;
    logic uartTxToLin;

    // decoded select fields
    always_comb begin
        selUartRx   = p1Sel_r[slp_pkg::P1_UART_RX_BIT];
        selUartTx   = p1Sel_r[slp_pkg::P1_UART_TX_BIT];
        selLinTxIn  = p2Sel_r[slp_pkg::P2_LIN_TX_IN_BIT];
        selLinRxOut = p2Sel_r[slp_pkg::P2_LIN_RX_OUT_BIT];
        linRxEn     = p2Sel_r[slp_pkg::P2_LIN_RX_EN_BIT];
        uartTxToLin = p2Sel_r[slp_pkg::P2_UART_TX_LIN_BIT];
    end

    always_comb begin
        rt.sel = '0;
        rt.sel[slp_pkg::PIN_UART_RX]    = selUartRx;
        rt.sel[slp_pkg::PIN_UART_TX]    = selUartTx;
        rt.sel[slp_pkg::PIN_LIN_TX_IN]  = selLinTxIn;
        rt.sel[slp_pkg::PIN_LIN_RX_OUT] = selLinRxOut;
    end

    // input-function pins are released, output-function pins driven
    always_comb begin
        rt.funcOut   = '0;
        rt.funcDrive = '0;
        rt.funcOut[slp_pkg::PIN_UART_TX]      = uartTx;
        rt.funcDrive[slp_pkg::PIN_UART_TX]    = 1'b1;
        rt.funcOut[slp_pkg::PIN_LIN_RX_OUT]   = linRxd;
        rt.funcDrive[slp_pkg::PIN_LIN_RX_OUT] = 1'b1;
        rt.gpioOut = gpioOut;
        rt.gpioOeN = gpioOeN;
    end

    slp_pin_select #(.N(slp_pkg::PIN_COUNT)) uSel (
        .rt (rt.mux)
    );

    // ****************************************************************
    // serial and lin line routing, all outputs registered
    // ****************************************************************
    logic [3:0] pinOut_r;
    logic [3:0] pinOeN_r;
    logic       uartRx_r;
    logic       uartRx_nxt;
    logic       linTxd_r;
    logic       linTxd_nxt;
    logic       linSyncRx_r;
    logic       linSyncRx_nxt;
    logic       linDiagEn_r;
    logic       linDiagEn_nxt;

    // standalone pin input beats the uart path so an external master always
    // owns the line in that mode; lin receive beats the uart rx pin likewise
    always_comb begin
        if (selLinTxIn) begin
            linTxd_nxt = pinIn[slp_pkg::PIN_LIN_TX_IN];
        end else if (uartTxToLin) begin
            linTxd_nxt = uartTx;
        end else begin
            linTxd_nxt = linTxPad;
        end
        if (linRxEn) begin
            uartRx_nxt    = linRxd;
            linSyncRx_nxt = linRxd;
        end else if (selUartRx) begin
            uartRx_nxt    = pinIn[slp_pkg::PIN_UART_RX];
            linSyncRx_nxt = slp_pkg::LINE_IDLE;
        end else begin
            uartRx_nxt    = slp_pkg::LINE_IDLE;
            linSyncRx_nxt = slp_pkg::LINE_IDLE;
        end
        linDiagEn_nxt = ~linRxEn;
    end

    // pins reset released, serial lines reset idle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinOut_r    <= 4'h0;
            pinOeN_r    <= 4'hf;
            uartRx_r    <= 1'b1;
            linTxd_r    <= 1'b1;
            linSyncRx_r <= 1'b1;
            linDiagEn_r <= 1'b1;
        end else begin
            pinOut_r    <= rt.pinOut;
            pinOeN_r    <= rt.pinOeN;
            uartRx_r    <= uartRx_nxt;
            linTxd_r    <= linTxd_nxt;
            linSyncRx_r <= linSyncRx_nxt;
            linDiagEn_r <= linDiagEn_nxt;
        end
    end

    assign pinOut    = pinOut_r;
    assign pinOeN    = pinOeN_r;
    assign uartRx    = uartRx_r;
    assign linTxd    = linTxd_r;
    assign linSyncRx = linSyncRx_r;
    assign linDiagEn = linDiagEn_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    // uart tx pin
    uart_tx_pin_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(selUartTx) |-> pinOut[1] == $past(uartTx) && !pinOeN[1])
        else $error("uart tx pin not carrying uart data");
    uart_rx_pin_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(selUartRx && !linRxEn) |-> uartRx == $past(pinIn[0]) && pinOeN[0])
        else $error("uart rx not taken from its pin");
    lin_tx_pad_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(rstn && !uartTxToLin && !selLinTxIn) |-> linTxd == $past(linTxPad))
        else $error("lin transmit not from internal pad");
    uart_to_lin_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(uartTxToLin && !selLinTxIn) |-> linTxd == $past(uartTx))
        else $error("uart transmit not routed to lin");
    lin_rx_off_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(!linRxEn) |-> linSyncRx && linDiagEn)
        else $error("lin receive path not disabled");
    lin_rx_fan_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(linRxEn) |-> uartRx == $past(linRxd) && linSyncRx == $past(linRxd)
                           && !linDiagEn)
        else $error("lin receive not fed to uart and sync");
    lin_rx_out_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(selLinRxOut) |-> pinOut[3] == $past(linRxd) && !pinOeN[3])
        else $error("lin receive not driven on its pin");
    lin_tx_in_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(selLinTxIn) |-> linTxd == $past(pinIn[2]) && pinOeN[2])
        else $error("lin transmit pin not passed through");
    gpio_reset_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rstn) ##1 (p2Sel_r == 32'h0000_0000) |-> pinOut == $past(gpioOut)
                                                  || $past(p1Sel_r) != 32'h0000_0000)
        else $error("pins not gpio after reset");
endmodule
`default_nettype wire

// >>> design/slp_pin_select.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// per-pin choice between general-purpose and peripheral function
// ****************************************************************
module slp_pin_select #(
    parameter int N = 4
) (
    // routing group
    slp_route_if.mux rt
);
    // one identical mux per pin; oe is active low, 0 means driven
    for (genvar i = 0; i < N; i++) begin : gPin
        always_comb begin
            if (rt.sel[i]) begin
                rt.pinOut[i] = rt.funcOut[i];
                rt.pinOeN[i] = ~rt.funcDrive[i];
            end else begin
                rt.pinOut[i] = rt.gpioOut[i];
                rt.pinOeN[i] = rt.gpioOeN[i];
            end
        end
    end
endmodule
`default_nettype wire

// >>> inc/slp_pkg.sv
// ****************************************************************
// serial/lin pin function mux constants
// ****************************************************************
package slp_pkg;
    // register byte addresses and read-back decode
    localparam logic [31:0] P1_SEL_ADDR = 32'hffff_0d04;
    localparam logic [31:0] P2_SEL_ADDR = 32'hffff_0d08;
    localparam logic [31:0] STATUS_ADDR = 32'hffff_0d0c;

    // reset values, both selects come up in general-purpose mode
    localparam logic [31:0] P1_SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] P2_SEL_RESET = 32'h0000_0000;

    // field positions in the port-1 select register
    localparam int P1_UART_RX_BIT = 0;
    localparam int P1_UART_TX_BIT = 4;

    // field positions in the port-2 select register
    localparam int P2_LIN_TX_IN_BIT  = 0;
    localparam int P2_LIN_RX_OUT_BIT = 4;
    localparam int P2_LIN_RX_EN_BIT  = 16;
    localparam int P2_UART_TX_LIN_BIT = 20;

    // writable bits; reserved bits are not stored and read as zero
    localparam logic [31:0] P1_SEL_MASK = 32'h0000_0011;
    localparam logic [31:0] P2_SEL_MASK = 32'h0011_0011;

    // field positions in the status register
    localparam int ST_LIN_TXD_BIT  = 0;
    localparam int ST_LIN_RXD_BIT  = 1;
    localparam int ST_UART_RX_BIT  = 2;

    // pin indices inside the pin vectors
    localparam int PIN_COUNT      = 4;
    localparam int PIN_UART_RX    = 0;
    localparam int PIN_UART_TX    = 1;
    localparam int PIN_LIN_TX_IN  = 2;
    localparam int PIN_LIN_RX_OUT = 3;

    // serial lines idle high (recessive)
    localparam logic LINE_IDLE = 1'b1;
endpackage

// >>> inc/slp_route_if.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// per-pin routing between main block and pin mux
// ****************************************************************
interface slp_route_if #(
    parameter int N = 4
);
    logic [N-1:0] sel;
    logic [N-1:0] funcOut;
    logic [N-1:0] funcDrive;
    logic [N-1:0] gpioOut;
    logic [N-1:0] gpioOeN;
    logic [N-1:0] pinOut;
    logic [N-1:0] pinOeN;

    // main block supplies selects and sources, mux returns pin values
    modport ctrl (output sel, output funcOut, output funcDrive,
                  output gpioOut, output gpioOeN, input pinOut, input pinOeN);
    modport mux  (input sel, input funcOut, input funcDrive,
                  input gpioOut, input gpioOeN, output pinOut, output pinOeN);
endinterface
`default_nettype wire
